/* File: dv/flash_mv_props.sv */
// Port assertions of the margin and erase-verify sequencer.
`timescale 1ns/1ps
module flash_mv_props (
  input wire clk, // clock
  input wire reset, // reset
  input wire [3:0] avs_address, // address
  input wire avs_read, // read
  input wire avs_write, // write
  input wire [31:0] avs_writedata, // write data
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // wait
  input wire df_rd, // flash read
  input wire [2:0] df_level, // level
  input wire stop_req, // stop request
  input wire stop_ack, // stop grant
  input wire cmd_irq // command irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire st_ok = !avs_waitrequest && avs_address == 4'h3;
  wire launch = avs_write && st_ok && avs_writedata[7];
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("access not answered after one wait");
  property p_wlow; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wlow: assert property (p_wlow) else $error("wait low for more than one cycle");
  property p_pv; avs_read && st_ok |-> !avs_readdata[4]; endproperty
  a_pv: assert property (p_pv) else $error("protection flag set");
  property p_rdpls; df_rd |=> !df_rd; endproperty
  a_rdpls: assert property (p_rdpls) else $error("flash read strobe too long");
  property p_stop; stop_ack |-> $past(stop_req); endproperty
  a_stop: assert property (p_stop) else $error("stop granted without request");
  property p_lvl; df_level <= 3'h4; endproperty
  a_lvl: assert property (p_lvl) else $error("level out of range");
  property p_lvlsrc; $changed(df_level) |-> $past(launch) || $past(launch, 2); endproperty
  a_lvlsrc: assert property (p_lvlsrc) else $error("level changed without launch");
  property p_cie; avs_write && !avs_waitrequest && avs_address == 4'h0 && !avs_writedata[0]
    |=> ##1 !cmd_irq; endproperty
  a_cie: assert property (p_cie) else $error("command irq while disabled");
endmodule // flash_mv_props
bind flash_margin_verify flash_mv_props i_props (.clk, .reset, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .df_rd, .df_level, .stop_req,
  .stop_ack, .cmd_irq);

/* File: dv/tb.sv */
// Self-checking bench of the margin and erase-verify sequencer.
`timescale 1ns/1ps
module tb;
  localparam W = 64;
  reg clk = 0, reset = 1, avs_read = 0, avs_write = 0, stop_req = 0, df_uncorr = 0;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0, q;
  reg [15:0] df_rdata = 16'h5A5A;
  reg [5:0] mg = 6'h00;
  integer n_fail = 0, check_count = 0, bad = -1, unc = -1, k;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, df_rd, stop_ack, cmd_irq, irq;
  wire [5:0] df_addr;
  wire [2:0] df_level, pf_level;
  flash_margin_verify #(.DF_WORDS(W), .DF_AW(6)) i_dut (.clk, .reset, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .df_rd, .df_addr, .df_rdata, .df_uncorr, .df_level, .pf_level,
    .stop_req, .stop_ack, .cmd_irq, .irq);
  always #2.5 clk = ~clk;
  // Flash words are erased except one bad word; off-read cycles show a non-erased pattern.
  always @(posedge clk) begin
    df_rdata <= !df_rd ? 16'h5A5A : (df_addr == bad ? 16'h0F0F : 16'hFFFF);
    df_uncorr <= df_rd && df_addr == unc;
  end
  task bus(input rw, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      avs_read <= !rw;
      avs_write <= rw;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n >= 50) chk(1, 0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task run(input [7:0] c, input [6:0] b, input [15:0] w1, input [15:0] w2, input [2:0] ix,
    input [7:0] st);
    integer i;
    begin
      bus(1, 4'h1, 32'h0);
      bus(1, 4'h2, {16'h0, c, 1'b0, b});
      bus(1, 4'h1, 32'h1);
      bus(1, 4'h2, {16'h0, w1});
      bus(1, 4'h1, 32'h2);
      bus(1, 4'h2, {16'h0, w2});
      bus(1, 4'h1, {29'h0, ix});
      bus(1, 4'h3, 32'h80);
      q = 0;
      for (i = 0; i < 400 && q[7] !== 1'b1; i = i + 1)
        bus(0, 4'h3, 0);
      chk(q, {24'h0, st});
      if (st[5])
        bus(1, 4'h3, 32'h20);
      bus(0, 4'h6, 0);
      chk(q, {26'h0, mg}); // level per block
      chk(df_level, mg[2:0]); // level on read path
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    bus(0, 4'h3, 0);
    chk(q, 32'h80); // idle status
    bus(0, 4'hF, 0);
    chk(q, 32'h0);
    for (k = 0; k < 3; k = k + 1) begin
      mg[2:0] = k;
      run(8'h0D, 7'h10, k, 0, 1, 8'h80); // user levels
    end
    mg[5:3] = 3'h1;
    run(8'h0D, 7'h7F, 1, 0, 1, 8'h80); // other block
    run(8'h0D, 7'h10, 3, 0, 1, 8'hA0); // bad setting
    run(8'h0D, 7'h33, 1, 0, 1, 8'hA0); // bad block
    run(8'h0D, 7'h10, 1, 0, 2, 8'hA0); // bad index
    run(8'h0E, 7'h10, 1, 0, 1, 8'hA0); // normal mode
    bus(1, 4'h0, 32'h2);
    for (k = 3; k < 5; k = k + 1) begin
      mg[2:0] = k;
      run(8'h0E, 7'h10, k, 0, 1, 8'h80); // field levels
    end
    run(8'h0E, 7'h10, 5, 0, 1, 8'hA0); // bad setting
    $display("margin tests done");
    run(8'h10, 7'h10, W - 4, 4, 2, 8'h80); // range at end
    run(8'h10, 7'h10, W - 2, 4, 2, 8'hA0); // past end
    run(8'h10, 7'h10, 5, 2, 2, 8'hA0); // odd start
    run(8'h10, 7'h7F, 4, 2, 2, 8'hA0); // bad address
    run(8'h10, 7'h10, 4, 2, 1, 8'hA0); // bad index
    bad <= 9;
    run(8'h10, 7'h10, 8, 4, 2, 8'h82); // verify error
    mg[2:0] = 0;
    run(8'h0D, 7'h10, 0, 0, 1, 8'h82); // flags untouched
    bad <= -1;
    unc <= 6;
    run(8'h10, 7'h10, 4, 4, 2, 8'h83); // uncorrectable
    $display("verify tests done");
    bus(1, 4'h5, 32'h7);
    bus(1, 4'h0, 32'h3);
    repeat (2) @(posedge clk);
    chk(cmd_irq, 1); // enabled irq
    chk(irq, 1);
    bus(0, 4'h4, 0);
    chk(q, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    bus(1, 4'h0, 32'h2);
    repeat (2) @(posedge clk);
    chk(cmd_irq, 0); // disabled irq
    stop_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk(stop_ack, 1); // idle stop
    $display("irq and stop tests done");
    end_sim;
  end
endmodule // tb

/* File: hdl/flash_cmd_map.vh */
// Register offsets, field positions, codes and reset values of the margin/verify sequencer.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
// Register word offsets (byte address = 4 * offset).
`define OFS_CTRL 4'h0
`define OFS_INDEX 4'h1
`define OFS_WORD 4'h2
`define OFS_STATUS 4'h3
`define OFS_IRQ_STAT 4'h4
`define OFS_IRQ_MASK 4'h5
`define OFS_MARGIN 4'h6
// Control register bits.
`define CTRL_CIE_BIT 0
`define CTRL_SPECIAL_BIT 1
// Status register bits (write one to clear ACC; PV always reads zero; write one to CCF launches).
`define ST_CCF_BIT 7
`define ST_ACC_BIT 5
`define ST_PV_BIT 4
`define ST_VERR_BIT 1
`define ST_VUNC_BIT 0
// Event bits of the sticky interrupt status.
`define EV_DONE_BIT 0
`define EV_ACC_BIT 1
`define EV_VERR_BIT 2
// Command codes.
`define CMD_USER_MARGIN 8'h0D
`define CMD_FIELD_MARGIN 8'h0E
`define CMD_ERASE_VERIFY 8'h10
// Word index values required at launch.
`define IX_MARGIN 3'h1
`define IX_VERIFY 3'h2
// Margin level settings.
`define LVL_NORMAL 16'h0000
`define LVL_USER_MAX 16'h0002
`define LVL_FIELD_MAX 16'h0004
// Reset values.
`define RST_CTRL 2'h0
`define RST_MASK 3'h0
`define RST_LEVEL 3'h0
// Data flash geometry and block ids (global address bits 22:16).
`define DF_BLOCK_ID 7'h10
`define PF_BLOCK_ID 7'h7F
`define ERASED_WORD 16'hFFFF
`endif

/* File: hdl/flash_margin_verify.v */
// Margin level and data flash section erase-verify command sequencer.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_margin_verify #(
  parameter DF_WORDS = 16384,
  parameter DF_AW = 15
) (
  input wire clk, // 200 MHz clock
  input wire reset, // Synchronous reset, active high
  input wire [3:0] avs_address, // Register word address
  input wire avs_read, // Avalon read
  input wire avs_write, // Avalon write
  input wire [31:0] avs_writedata, // Avalon write data
  input wire [3:0] avs_byteenable, // Avalon byte enables
  output reg [31:0] avs_readdata, // Avalon read data
  output reg avs_waitrequest, // Avalon wait request
  output reg df_rd, // Data flash read strobe
  output reg [DF_AW-1:0] df_addr, // Data flash word address
  input wire [15:0] df_rdata, // Data flash read word, next cycle
  input wire df_uncorr, // Uncorrectable fault with the read word
  output reg [2:0] df_level, // Margin level for data flash reads
  output reg [2:0] pf_level, // Margin level for program flash reads
  input wire stop_req, // Stop mode request (same clock)
  output reg stop_ack, // Stop may be entered
  output reg cmd_irq, // Command complete interrupt request
  output reg irq // Masked sticky event interrupt
);
  // --------------------------------------------------------------
  // Sequencer states and storage.
  // --------------------------------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_READ = 2'd1;
  localparam S_CHECK = 2'd2;
  localparam S_DONE = 2'd3;

  reg [1:0] state_q;
  reg [15:0] words_q [0:7];
  reg [2:0] index_q;
  reg [1:0] ctrl_q;
  reg ccf_q, acc_q, verr_q, vunc_q;
  reg [2:0] ev_q, mask_q;
  reg [DF_AW-1:0] ptr_q;
  reg [16:0] left_q;
  reg wait_q;

  // --------------------------------------------------------------
  // Decoding helpers.
  // --------------------------------------------------------------
  // Validity of a block id given as global address bits 22:16.
  function blk_ok;
    input [6:0] id;
    begin
      blk_ok = (id == `DF_BLOCK_ID) || (id == `PF_BLOCK_ID);
    end
  endfunction

  // Highest setting that a margin command accepts.
  function [15:0] lvl_max;
    input field;
    begin
      lvl_max = field ? `LVL_FIELD_MAX : `LVL_USER_MAX;
    end
  endfunction

  // --------------------------------------------------------------
  // Command word fields.
  // --------------------------------------------------------------
  // word layout
  wire [7:0] code = words_q[0][15:8];
  wire [6:0] blk = words_q[0][6:0];
  wire [15:0] setting = words_q[1];
  wire [15:0] start = words_q[1];
  wire [15:0] count = words_q[2];
  wire special = ctrl_q[`CTRL_SPECIAL_BIT];
  wire sel = avs_read | avs_write;
  wire acc_wr = avs_write & ~wait_q;
  wire acc_rd = avs_read & ~wait_q;
  // A launch is refused while an access error is pending or stop is requested.
  wire launch = acc_wr && avs_address == `OFS_STATUS && avs_byteenable[0] &&
    avs_writedata[`ST_CCF_BIT] && ccf_q && !acc_q && !stop_req;
  // The end is two bits wider than the operands so that a wrap cannot hide an overrun.
  wire [17:0] range_end = {2'b00, start} + {2'b00, count};

  // --------------------------------------------------------------
  // Parameter checks at launch.
  // --------------------------------------------------------------

  reg bad;
  always @* begin
    bad = 1'b0;
    case (code)
      `CMD_USER_MARGIN: begin
        bad = (index_q != `IX_MARGIN) || !blk_ok(blk);
        if (setting > lvl_max(1'b0)) bad = 1'b1;
      end
      `CMD_FIELD_MARGIN: begin
        bad = (index_q != `IX_MARGIN) || !special || !blk_ok(blk);
        if (setting > lvl_max(1'b1)) bad = 1'b1;
      end
      `CMD_ERASE_VERIFY: begin
        bad = (index_q != `IX_VERIFY);
        if ((blk != `DF_BLOCK_ID) || (start >= DF_WORDS)) bad = 1'b1;
        if (start[0]) bad = 1'b1;
        if (range_end > DF_WORDS) bad = 1'b1;
      end
      default: bad = 1'b1;
    endcase
  end

  // --------------------------------------------------------------
  // Bus slave: one wait cycle per access.
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      wait_q <= 1'b1;
      avs_waitrequest <= 1'b1;
    end else begin
      wait_q <= sel ? ~wait_q : 1'b1;
      avs_waitrequest <= ~(sel & wait_q);
    end
  end

  integer i;
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 8; i = i + 1) words_q[i] <= 16'h0000;
      index_q <= 3'h0;
      ctrl_q <= `RST_CTRL;
      mask_q <= `RST_MASK;
      avs_readdata <= 32'h0000_0000;
    end else begin
      if (acc_wr && ccf_q) begin
        if (avs_address == `OFS_INDEX) index_q <= avs_writedata[2:0];
        if (avs_address == `OFS_WORD) words_q[index_q] <= avs_writedata[15:0];
      end
      if (acc_wr && avs_address == `OFS_CTRL) ctrl_q <= avs_writedata[1:0];
      if (acc_wr && avs_address == `OFS_IRQ_MASK) mask_q <= avs_writedata[2:0];
      // Read data are loaded in the wait cycle, so that they already stand
      // at the edge where the master sees waitrequest low.
      if (avs_read && wait_q) begin
        case (avs_address)
          `OFS_CTRL: avs_readdata <= {30'h0, ctrl_q};
          `OFS_INDEX: avs_readdata <= {29'h0, index_q};
          `OFS_WORD: avs_readdata <= {16'h0, words_q[index_q]};
          `OFS_STATUS: avs_readdata <= {24'h0, ccf_q, 1'b0, acc_q, 1'b0, 2'b00,
            verr_q, vunc_q};
          `OFS_IRQ_STAT: avs_readdata <= {29'h0, ev_q};
          `OFS_IRQ_MASK: avs_readdata <= {29'h0, mask_q};
          `OFS_MARGIN: avs_readdata <= {26'h0, pf_level, df_level};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Command sequencer.
  // --------------------------------------------------------------
  wire clr_acc = acc_wr && avs_address == `OFS_STATUS && avs_byteenable[0] &&
    avs_writedata[`ST_ACC_BIT];
  reg set_acc, set_verr, set_done;
  always @(posedge clk) begin
    if (reset) begin
      state_q <= S_IDLE;
      ccf_q <= 1'b1;
      acc_q <= 1'b0;
      verr_q <= 1'b0;
      vunc_q <= 1'b0;
      df_level <= `RST_LEVEL;
      pf_level <= `RST_LEVEL;
      df_rd <= 1'b0;
      df_addr <= {DF_AW{1'b0}};
      ptr_q <= {DF_AW{1'b0}};
      left_q <= 17'h0;
      set_acc <= 1'b0;
      set_verr <= 1'b0;
      set_done <= 1'b0;
    end else begin
      set_acc <= 1'b0;
      set_verr <= 1'b0;
      set_done <= 1'b0;
      df_rd <= 1'b0;
      if (clr_acc) acc_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (launch) begin
            ccf_q <= 1'b0;
            if (bad) begin
              acc_q <= 1'b1;
              set_acc <= 1'b1;
              state_q <= S_DONE;
            end else if (code == `CMD_ERASE_VERIFY) begin
              verr_q <= 1'b0;
              vunc_q <= 1'b0;
              ptr_q <= start[DF_AW-1:0];
              left_q <= {1'b0, count};
              state_q <= (count == 16'h0) ? S_DONE : S_READ;
            end else begin
              if (blk == `DF_BLOCK_ID) df_level <= setting[2:0];
              else pf_level <= setting[2:0];
              state_q <= S_DONE;
            end
          end
        end
        S_READ: begin
          df_rd <= 1'b1;
          df_addr <= ptr_q;
          state_q <= S_CHECK;
        end
        S_CHECK: begin
          // The read word arrives one cycle after the strobe, so the first
          // cycle here only waits for it.
          if (!df_rd) begin
            if (df_rdata != `ERASED_WORD || df_uncorr) begin
              verr_q <= 1'b1;
              set_verr <= 1'b1;
            end
            if (df_uncorr) vunc_q <= 1'b1;
            ptr_q <= ptr_q + {{(DF_AW-1){1'b0}}, 1'b1};
            left_q <= left_q - 17'h1;
            state_q <= (left_q == 17'h1) ? S_DONE : S_READ;
          end
        end
        default: begin
          ccf_q <= 1'b1;
          set_done <= 1'b1;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Interrupts and stop handshake.
  // --------------------------------------------------------------
  wire rd_ev = acc_rd && avs_address == `OFS_IRQ_STAT;
  wire [2:0] ev_set = {set_verr, set_acc, set_done};
  // A set in the cycle of a read clear wins; an event set in the read's wait cycle is cleared unread.
  wire [2:0] ev_keep = rd_ev ? 3'h0 : ev_q;
  wire [2:0] ev_next = ev_keep | ev_set;
  always @(posedge clk) begin
    if (reset) begin
      ev_q <= 3'h0;
      irq <= 1'b0;
      cmd_irq <= 1'b0;
      stop_ack <= 1'b0;
    end else begin
      ev_q <= ev_next;
      irq <= |(ev_next & mask_q);
      cmd_irq <= ccf_q & ctrl_q[`CTRL_CIE_BIT];
      stop_ack <= stop_req & ccf_q & (state_q == S_IDLE);
    end
  end
endmodule // flash_margin_verify
